// ===== hw/gppp_pin_cell.sv
// One pin driver of the general purpose pin port: chooses between the
// alternate function and software control and registers the pad drive.
// Assumes pclk/presetn of the register bus; the pad wire is resolved
// outside from pad_out and pad_oe.

`timescale 1ns/10ps
`default_nettype none

module gppp_pin_cell
    import gppp_pkg::*;
(
    // Clock and fundamental reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Control from the register file
    input  wire logic sel_alt,
    input  wire logic dir_out,
    input  wire logic sw_level,
    // Alternate function drive
    input  wire logic alt_out,
    input  wire logic alt_oe,
    // Pad side
    output var  logic pad_out,
    output var  logic pad_oe
);

    // ************************************************************
    // Pad drive selection
    // ************************************************************
    // The drive is registered so that the pad never sees a glitch from
    // the select mux; this costs one cycle of latency on alternate and software drive alike.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_out <= 1'b0;
            pad_oe  <= 1'b0;
        end else if (sel_alt) begin
            pad_out <= alt_out;
            pad_oe  <= alt_oe;
        end else begin
            pad_out <= sw_level;
            pad_oe  <= dir_out;
        end
    end

endmodule

`default_nettype wire

// ===== hw/gppp_pkg.sv
// Package of the general purpose pin port: register map, field layout,
// reset values and widths shared by the port and its pin cells.
// Assumes a 32-bit APB register bus with byte addresses.

package gppp_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int unsigned GPPP_PINS       = 16;
    localparam int unsigned GPPP_ADDR_W     = 12;
    localparam int unsigned GPPP_DATA_W     = 32;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [11:0] GPPP_OFF_FUNC   = 12'h418;
    localparam logic [11:0] GPPP_OFF_DIR    = 12'h41C;
    localparam logic [11:0] GPPP_OFF_LEVEL  = 12'h420;

    // ************************************************************
    // Field layout and values after fundamental reset
    // ************************************************************
    localparam int unsigned GPPP_FIELD_LSB  = 0;
    localparam int unsigned GPPP_FIELD_MSB  = 15;
    localparam logic [15:0] GPPP_FUNC_RST   = 16'h0000;
    localparam logic [15:0] GPPP_DIR_RST    = 16'h0000;
    localparam logic [15:0] GPPP_LEVEL_RST  = 16'h0000;
    localparam logic [15:0] GPPP_RSVD_BITS  = 16'h0000;
    localparam logic [31:0] GPPP_RDATA_RST  = 32'h0000_0000;

endpackage

// ===== hw/gppp_port.sv
// Contract
// - Function-select bit one hands that pin to its alternate function.
// - Function-select bit zero makes that pin a software-controlled pin.
// - Software pin with direction bit one is driven as an output.
// - Software pin with direction bit zero is an input, driver off.
// - Alternate-function pins take direction and drive from that function.
// - Reading the level register returns every pin's present level.
// - Writing the level register changes only software output pins.
//
// Sixteen-pin general purpose port with an APB register slave.
// Assumes pin inputs are synchronous to pclk, presetn is the fundamental
// reset and warm_rst_n a synchronous warm reset from the reset controller.

`timescale 1ns/10ps
`default_nettype none

module gppp_port
    import gppp_pkg::*;
#(
    parameter int unsigned PINS   = GPPP_PINS,
    parameter int unsigned ADDR_W = GPPP_ADDR_W
)
(
    // Clock and resets
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              warm_rst_n,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output var  logic [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Alternate functions
    input  wire logic [PINS-1:0]   alt_out,
    input  wire logic [PINS-1:0]   alt_oe,
    output logic [PINS-1:0]        alt_in,
    // Pins
    input  wire logic [PINS-1:0]   gpio_in,
    output logic [PINS-1:0]        gpio_out,
    output logic [PINS-1:0]        gpio_oe
);

    // ************************************************************
    // Registers and decode
    // ************************************************************
    logic [PINS-1:0] pin_function_select;
    logic [PINS-1:0] pin_direction;
    logic [PINS-1:0] pin_level;
    logic [PINS-1:0] sw_out_mask;
    logic            setup_rd;
    logic            access_wr;

    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                      input logic [11:0]       off);
        addr_hit = (addr == off[ADDR_W-1:0]);
    endfunction

    function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
        addr_mapped = addr_hit(addr, GPPP_OFF_FUNC) ||
                      addr_hit(addr, GPPP_OFF_DIR)  ||
                      addr_hit(addr, GPPP_OFF_LEVEL);
    endfunction

    assign setup_rd    = psel && !penable && !pwrite;
    assign access_wr   = psel && penable && pwrite && addr_mapped(paddr);
    assign sw_out_mask = ~pin_function_select & pin_direction;

    // Zero wait states; unmapped addresses answer with an error.
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_mapped(paddr);

    // ************************************************************
    // Sticky configuration
    // ************************************************************
    // Only the fundamental reset clears these; a warm reset must leave
    // a board's pin assignment intact while the rest of the chip restarts.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_function_select <= GPPP_FUNC_RST;
        end else if (access_wr && addr_hit(paddr, GPPP_OFF_FUNC)) begin
            pin_function_select <= pwdata[PINS-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_direction <= GPPP_DIR_RST;
        end else if (access_wr && addr_hit(paddr, GPPP_OFF_DIR)) begin
            pin_direction <= pwdata[PINS-1:0];
        end
    end

    // Bits of pins that are not software outputs keep their old value.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_level <= GPPP_LEVEL_RST;
        end else if (access_wr && addr_hit(paddr, GPPP_OFF_LEVEL)) begin
            pin_level <= (pwdata[PINS-1:0] & sw_out_mask) |
                         (pin_level & ~sw_out_mask);
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    // Read data are captured in the setup cycle so they are stable from
    // a flop through the whole access phase. Warm reset clears them.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= GPPP_RDATA_RST;
        end else if (!warm_rst_n) begin
            prdata <= GPPP_RDATA_RST;
        end else if (setup_rd) begin
            prdata <= GPPP_RDATA_RST;
            if (addr_hit(paddr, GPPP_OFF_FUNC)) begin
                prdata[PINS-1:0] <= pin_function_select;
            end else if (addr_hit(paddr, GPPP_OFF_DIR)) begin
                prdata[PINS-1:0] <= pin_direction;
            end else if (addr_hit(paddr, GPPP_OFF_LEVEL)) begin
                prdata[PINS-1:0] <= gpio_in;
            end
        end
    end

    // ************************************************************
    // Pin cells
    // ************************************************************
    // The alternate function always sees the live pin level.
    assign alt_in = gpio_in;

    for (genvar i = 0; i < PINS; i++) begin : g_pin
        gppp_pin_cell u_cell (
            .pclk     (pclk),
            .presetn  (presetn),
            .sel_alt  (pin_function_select[i]),
            .dir_out  (pin_direction[i]),
            .sw_level (pin_level[i]),
            .alt_out  (alt_out[i]),
            .alt_oe   (alt_oe[i]),
            .pad_out  (gpio_out[i]),
            .pad_oe   (gpio_oe[i])
        );
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_alt_out;
        @(posedge pclk) disable iff (!presetn)
        ##1 ((gpio_out & $past(pin_function_select)) ==
             ($past(alt_out) & $past(pin_function_select)));
    endproperty
    a_alt_out: assert property (p_alt_out)
        else $error("Alternate pin does not carry its function output.");

    property p_sw_level;
        @(posedge pclk) disable iff (!presetn)
        ##1 ((gpio_out & ~$past(pin_function_select)) ==
             ($past(pin_level) & ~$past(pin_function_select)));
    endproperty
    a_sw_level: assert property (p_sw_level)
        else $error("Software pin does not carry the level register.");

    property p_sw_drive;
        @(posedge pclk) disable iff (!presetn)
        ##1 ((gpio_oe & $past(sw_out_mask)) == $past(sw_out_mask));
    endproperty
    a_sw_drive: assert property (p_sw_drive)
        else $error("Software output pin is not driven.");

    property p_sw_input;
        @(posedge pclk) disable iff (!presetn)
        ##1 ((gpio_oe & ~$past(pin_function_select) &
              ~$past(pin_direction)) == '0);
    endproperty
    a_sw_input: assert property (p_sw_input)
        else $error("Software input pin has its driver on.");

    property p_alt_oe;
        @(posedge pclk) disable iff (!presetn)
        ##1 ((gpio_oe & $past(pin_function_select)) ==
             ($past(alt_oe) & $past(pin_function_select)));
    endproperty
    a_alt_oe: assert property (p_alt_oe)
        else $error("Alternate pin enable does not follow its function.");

    property p_level_read;
        @(posedge pclk) disable iff (!presetn)
        (setup_rd && warm_rst_n && addr_hit(paddr, GPPP_OFF_LEVEL))
        |=> (prdata[PINS-1:0] == $past(gpio_in)) &&
            (prdata[31:PINS] == '0);
    endproperty
    a_level_read: assert property (p_level_read)
        else $error("Level read does not return the pin levels.");

    property p_level_write;
        @(posedge pclk) disable iff (!presetn)
        (access_wr && addr_hit(paddr, GPPP_OFF_LEVEL))
        |=> ((pin_level & $past(sw_out_mask)) ==
             ($past(pwdata[PINS-1:0]) & $past(sw_out_mask))) &&
            ((pin_level & ~$past(sw_out_mask)) ==
             ($past(pin_level) & ~$past(sw_out_mask)));
    endproperty
    a_level_write: assert property (p_level_write)
        else $error("Level write touched a pin that is not an output.");

    property p_sticky;
        @(posedge pclk) disable iff (!presetn)
        (!warm_rst_n && !access_wr)
        |=> $stable(pin_function_select) && $stable(pin_direction);
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("Warm reset disturbed sticky pin configuration.");

endmodule

`default_nettype wire

// ===== test/gppp_board.sv
// Board model for the general purpose pin port: resolves each pad wire.
// Assumes the bench sets what the board drives on pads the port leaves.
`timescale 1ns/10ps
`default_nettype none

module gppp_board (
    // Pad drive from the port
    input  wire logic [15:0] gpio_out,
    input  wire logic [15:0] gpio_oe,
    // Board side
    input  wire logic [15:0] ext_level,
    output logic [15:0]      gpio_in
);
    // A driven pad follows the port, so the board never fights it.
    assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ext_level);
endmodule

`default_nettype wire

// ===== test/gppp_port_tb.sv
// Self-checking bench of the general purpose pin port over APB.
// Assumes the port answers APB without a fixed wait and the board model.
`timescale 1ns/10ps
`default_nettype none

module gppp_port_tb;
    import gppp_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, warm_rst_n = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err;
    logic [15:0] alt_out = 16'h0, alt_oe = 16'h0, ext_level = 16'h0;
    logic [15:0] alt_in, gpio_in, gpio_out, gpio_oe;
    int          err_count = 0, n_checks = 0;

    always #25 pclk = ~pclk;

    gppp_port #(.PINS(16), .ADDR_W(12)) dut (
        .pclk(pclk), .presetn(presetn), .warm_rst_n(warm_rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .alt_out(alt_out), .alt_oe(alt_oe),
        .alt_in(alt_in), .gpio_in(gpio_in), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe));

    gppp_board board (.gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .ext_level(ext_level), .gpio_in(gpio_in));

    task print_verdict;
        $display("Checks %0d, errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // The request is held until pready is seen high at a rising edge.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            err_count++;
            $display("ERROR at %0t: no bus answer", $time);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdchk(input logic [11:0] a, input logic [31:0] e, input logic se);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
        chk({31'h0, err}, {31'h0, se});
    endtask

    // Pads follow the registers one edge after the write lands.
    task pins(input logic [15:0] oe, input logic [15:0] outv);
        repeat (2) @(posedge pclk);
        #1;
        chk({16'h0, gpio_oe}, {16'h0, oe});
        chk({16'h0, gpio_out & oe}, {16'h0, outv & oe});
    endtask

    task t_reset;
        rdchk(GPPP_OFF_FUNC, 32'h0, 1'b0);
        rdchk(GPPP_OFF_DIR, 32'h0, 1'b0);
        rdchk(12'h424, 32'h0, 1'b1);
        pins(16'h0000, 16'h0000);
    endtask

    task t_sw_out;
        ext_level <= 16'h5A00;
        apb(1'b1, GPPP_OFF_DIR, 32'hFFFF_00FF);
        apb(1'b1, GPPP_OFF_LEVEL, 32'h0000_A5A5);
        pins(16'h00FF, 16'h00A5);
        rdchk(GPPP_OFF_DIR, 32'h0000_00FF, 1'b0);
        rdchk(GPPP_OFF_LEVEL, 32'h0000_5AA5, 1'b0);
    endtask

    task t_latch;
        apb(1'b1, GPPP_OFF_LEVEL, 32'h0000_FFFF);
        apb(1'b1, GPPP_OFF_DIR, 32'h0000_FFFF);
        pins(16'hFFFF, 16'h00FF);
    endtask

    task t_alt;
        alt_out <= 16'h0FF0;
        alt_oe <= 16'h00FF;
        apb(1'b1, GPPP_OFF_FUNC, 32'h0000_0F0F);
        pins(16'hF0FF, 16'h0FF0);
        apb(1'b1, GPPP_OFF_LEVEL, 32'h0000_0000);
        pins(16'hF0FF, 16'h0F00);
        rdchk(GPPP_OFF_LEVEL, 32'h0000_0A00, 1'b0);
        chk({16'h0, alt_in}, 32'h0000_0A00);
    endtask

    task t_resets;
        @(posedge pclk);
        warm_rst_n <= 1'b0;
        repeat (2) @(posedge pclk);
        warm_rst_n <= 1'b1;
        rdchk(GPPP_OFF_FUNC, 32'h0000_0F0F, 1'b0);
        rdchk(GPPP_OFF_DIR, 32'h0000_FFFF, 1'b0);
        pins(16'hF0FF, 16'h0F00);
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        rdchk(GPPP_OFF_FUNC, 32'h0, 1'b0);
        pins(16'h0000, 16'h0000);
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_sw_out;
        t_latch;
        t_alt;
        t_resets;
        print_verdict;
    end

    // The tests need under a hundred cycles; this cuts a hang short.
    initial begin
        repeat (5000) @(posedge pclk);
        err_count++;
        print_verdict;
    end
endmodule

`default_nettype wire
